// [rtl/msc_ctrl.v]
// Purpose : control and alert pin logic of a temperature monitor / fan controller
// Assumes : thermal comparisons arrive from logic on sys_clk_i
// Notes   : open-drain pins are driven low while their _oe_n_o is low
//           standby reset returns every core register to its reset value, the power-off latch included
//           a second remote reset request while a pulse runs restarts the count
//           with main power gone the fan stays stopped even during an overtemp
//           pin inputs reach the logic about four cycles after they change
`timescale 1ns/10ps
`include "msc_consts.vh"

module msc_ctrl
(
  input  wire        sys_clk_i,        // 250 MHz clock
  input  wire        nrst_i,           // power-on reset, low active
  input  wire [4:0]  avs_address_i,    // byte address
  input  wire        avs_read_i,       // read request
  input  wire        avs_write_i,      // write request
  input  wire [3:0]  avs_byteenable_i, // byte lanes
  input  wire [31:0] avs_writedata_i,  // write data
  output reg  [31:0] avs_readdata_o,   // read data
  output reg         avs_waitrequest_o,// stall
  input  wire        temp_setpoint_violated_i, // hardware set point exceeded
  input  wire        trip_point_violated_i,    // programmed limit exceeded
  input  wire        general_purpose_input_i,  // pin, async
  input  wire        standby_reset_in_n_i,     // pin, async
  input  wire        main_power_loss_n_i,      // pin, async
  input  wire        fan_speed_analog_or_test_select_i, // shared pin sense
  output reg  [7:0]  fan_speed_code_o,         // analog fan level
  output reg         fan_speed_oe_n_o,         // fan analog drive enable
  output reg         fan_off_req_out_o,        // open-drain level
  output reg         fan_off_req_oe_n_o,       // open-drain enable
  output reg         remote_reset_out_o,       // open-drain level
  output reg         remote_reset_oe_n_o,      // open-drain enable
  output reg         overtemp_out_primary_n_out_o,   // open-drain level
  output reg         overtemp_out_primary_n_oe_n_o,  // open-drain enable
  output reg         overtemp_out_secondary_n_out_o, // open-drain level
  output reg         overtemp_out_secondary_n_oe_n_o,// open-drain enable
  output reg         int_pin_out_o,            // open-drain level
  output reg         int_pin_oe_n_o,           // open-drain enable
  output reg         remote_power_off_o,       // push-pull, high = off
  output reg         irq_o                     // level interrupt
);

  // ==================================================================
  // address decode of the write paths; the read path decodes in its own case
  // exact match on the five byte-address bits; unused offsets decode to nothing
  function hit;
    input [4:0] a;
    input [4:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // ==================================================================
  // pin synchronisers: three stages, a change counts once stage 2 and 3 agree
  // the filter costs four cycles of latency but rejects a one-cycle glitch
  localparam NPIN = 4;
  // each stage resets to the idle level of its pin, so release shows no false event
  localparam [NPIN-1:0] PIN_IDLE = `MSC_RST_PINS;
  wire [NPIN-1:0] pin_raw;
  reg  [NPIN-1:0] sync1;
  reg  [NPIN-1:0] sync2;
  reg  [NPIN-1:0] sync3;
  reg  [NPIN-1:0] pin_f;
  // bit order: general input, standby reset, power loss, test select
  assign pin_raw = {fan_speed_analog_or_test_select_i, main_power_loss_n_i,
                    standby_reset_in_n_i, general_purpose_input_i};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_sync
      // reset and power pins idle high, general input and test select idle low
      always @(posedge sys_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          sync1[gi] <= PIN_IDLE[gi];
          sync2[gi] <= PIN_IDLE[gi];
          sync3[gi] <= PIN_IDLE[gi];
          pin_f[gi] <= PIN_IDLE[gi];
        end
        else
        begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi])
            pin_f[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // filtered pin levels; the standby reset and power pins are active low
  wire gpi_lvl   = pin_f[0];
  wire aux_ok    = pin_f[1];
  wire pwr_ok    = pin_f[2];
  wire test_mode = pin_f[3];

  // ==================================================================
  // core reset: a flop so the async reset of the core is glitch free
  // standby reset only reaches the core, the pin filters keep running
  reg core_rst_n;
  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      core_rst_n <= 1'b0;
    else
      core_rst_n <= aux_ok;
  end

  // ==================================================================
  // register state
  // software-visible registers
  reg [7:0]  cfg;
  reg [7:0]  istat;
  reg [7:0]  imask;
  reg [7:0]  fan_code;

  // remote function state
  reg        roff;
  reg        fan_off_req;
  reg [11:0] rrst_cnt;

  // remote reset length as a 12-bit load value; the count stays well below 4096
  localparam [31:0] RRST_LEN_W = `MSC_RRST_CYC;
  localparam [11:0] RRST_LEN   = RRST_LEN_W[11:0];
  wire rrst_busy = (rrst_cnt != 12'h000);

  // bus access strobes; only byte lane 0 carries register data
  wire acc    = ~avs_waitrequest_o;
  wire wr_acc = avs_write_i & acc & avs_byteenable_i[0];
  wire [7:0] wd = avs_writedata_i[7:0];

  // status events are levels: a bit re-sets every cycle its cause holds
  wire [7:0] gpi_ev = {3'h0, gpi_lvl == cfg[`MSC_CFG_GPI_POL], 4'h0};
  wire [7:0] ev = gpi_ev | {6'h00, temp_setpoint_violated_i, trip_point_violated_i};
  wire [7:0] w1c = (wr_acc && hit(avs_address_i, `MSC_OFF_ISTAT)) ? wd : 8'h00;
  wire [7:0] next_istat = ((istat & ~w1c) | ev) & `MSC_IST_USED;

  // remote message strobe and alert conditions
  wire rem_wr = wr_acc && hit(avs_address_i, `MSC_OFF_REMOTE);
  wire pending = |(istat & ~imask);
  wire therm = temp_setpoint_violated_i;

  // test chain: the three filtered inputs fold into one result bit,
  // so a stuck board net on any of them flips the result
  wire nand_res = ~(~(gpi_lvl & aux_ok) & pwr_ok);

  // ==================================================================
  // bus slave: one wait cycle, then waitrequest low with read data ready
  // address pointer and data byte of the serial protocol map onto address/data
  always @(posedge sys_clk_i or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else
    begin
      // waitrequest drops for one cycle per request; the master holds until then
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      // read data loads as waitrequest drops, so it stands at the accept edge
      if (avs_read_i && avs_waitrequest_o)
      begin
        case (avs_address_i)
          `MSC_OFF_CFG     : avs_readdata_o <= {24'h0, cfg};
          `MSC_OFF_ISTAT   : avs_readdata_o <= {24'h0, istat};
          `MSC_OFF_IMASK   : avs_readdata_o <= {24'h0, imask};
          `MSC_OFF_FANCODE : avs_readdata_o <= {24'h0, fan_code};
          `MSC_OFF_ALERT   : avs_readdata_o <= {28'h0, pwr_ok, test_mode, gpi_lvl, therm};
          `MSC_OFF_REMOTE  : avs_readdata_o <= {29'h0, fan_off_req, rrst_busy, roff};
          `MSC_OFF_SLVADDR : avs_readdata_o <= {24'h0, `MSC_SLAVE_ADDR};
          default          : avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==================================================================
  // writable registers; status set wins over a same-cycle clear
  always @(posedge sys_clk_i or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      cfg         <= `MSC_RST_CFG;
      istat       <= 8'h00;
      imask       <= `MSC_RST_IMASK;
      fan_code    <= `MSC_RST_FANCODE;
      fan_off_req <= 1'b0;
    end
    else
    begin
      // write-one-to-clear status; a same-cycle event wins over the clear
      istat <= next_istat;
      // configuration keeps only the polarity and interrupt enable bits
      if (wr_acc && hit(avs_address_i, `MSC_OFF_CFG))
        cfg <= wd & 8'h03;
      if (wr_acc && hit(avs_address_i, `MSC_OFF_IMASK))
        imask <= wd & `MSC_IST_USED;
      if (wr_acc && hit(avs_address_i, `MSC_OFF_FANCODE))
        fan_code <= wd;
      if (rem_wr)
        fan_off_req <= wd[`MSC_REM_FANOFF];
    end
  end

  // ==================================================================
  // remote functions: latched power-off and self-timed reset pulse
  // power loss is a level, so its clear overrides a same-cycle set
  always @(posedge sys_clk_i or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      roff     <= 1'b0;
      rrst_cnt <= 12'h000;
    end
    else
    begin
      // power-off latch
      if (!pwr_ok)
        roff <= 1'b0;
      else if (rem_wr && wd[`MSC_REM_OFF])
        roff <= 1'b1;
      // a new request reloads the count, so a running pulse is stretched
      if (rem_wr && wd[`MSC_REM_RST])
        rrst_cnt <= RRST_LEN;
      else if (rrst_busy)
        rrst_cnt <= rrst_cnt - 12'h001;
    end
  end

  // ==================================================================
  // pin outputs, all registered
  always @(posedge sys_clk_i or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      // every open-drain pin released, fan code at its reset level
      fan_speed_code_o                <= `MSC_RST_FANCODE;
      fan_speed_oe_n_o                <= 1'b1;
      fan_off_req_out_o               <= 1'b0;
      fan_off_req_oe_n_o              <= 1'b1;
      remote_reset_out_o              <= 1'b0;
      remote_reset_oe_n_o             <= 1'b1;
      overtemp_out_primary_n_out_o    <= 1'b0;
      overtemp_out_primary_n_oe_n_o   <= 1'b1;
      overtemp_out_secondary_n_out_o  <= 1'b0;
      overtemp_out_secondary_n_oe_n_o <= 1'b1;
      int_pin_out_o                   <= 1'b0;
      int_pin_oe_n_o                  <= 1'b1;
      remote_power_off_o              <= 1'b0;
      irq_o                           <= 1'b0;
    end
    else
    begin
      // stop beats full speed: with main power gone the fan cannot run anyway
      if (!pwr_ok)
        fan_speed_code_o <= `MSC_FAN_STOP;
      else if (therm)
        fan_speed_code_o <= `MSC_FAN_FULL;
      else
        fan_speed_code_o <= fan_code;
      // fan drive released in test mode, where the shared pin is an input
      fan_speed_oe_n_o   <= test_mode | ~pwr_ok;
      // open-drain pins: enable low pulls the pin low, the level stays zero
      fan_off_req_oe_n_o <= ~fan_off_req;
      remote_reset_oe_n_o <= ~rrst_busy;
      // primary alert: thermal cause normally, chain result in test mode
      overtemp_out_primary_n_oe_n_o <= test_mode ? nand_res : ~therm;
      // secondary alert follows the same cause on its own pull-up rail
      overtemp_out_secondary_n_oe_n_o <= ~therm;
      // interrupt pin needs the enable bit, irq_o does not
      int_pin_oe_n_o <= ~(pending & cfg[`MSC_CFG_INT_EN]);
      // power loss blocks the output on the same edge that clears the latch
      remote_power_off_o <= roff & pwr_ok;
      irq_o <= pending;
    end
  end

endmodule // msc_ctrl

// [rtl/msc_consts.vh]
// Purpose : constants of the monitor system control pin block
// Assumes : included by msc_ctrl.v, the assertions and the bench
// Notes   : byte addresses on the register bus, 8-bit data in the low lane
`ifndef MSC_CONSTS_VH
`define MSC_CONSTS_VH

// ====================================================================
// register byte offsets
`define MSC_OFF_CFG      5'h00
`define MSC_OFF_ISTAT    5'h04
`define MSC_OFF_IMASK    5'h08
`define MSC_OFF_FANCODE  5'h0c
`define MSC_OFF_ALERT    5'h10
`define MSC_OFF_REMOTE   5'h14
`define MSC_OFF_SLVADDR  5'h18

// ====================================================================
// field positions
`define MSC_CFG_GPI_POL  0
`define MSC_CFG_INT_EN   1
`define MSC_IST_TRIP     0
`define MSC_IST_THERM    1
`define MSC_IST_GPI      4
`define MSC_REM_OFF      0
`define MSC_REM_RST      1
`define MSC_REM_FANOFF   2

// ====================================================================
// reset values and fixed codes
`define MSC_RST_CFG      8'h01
`define MSC_RST_IMASK    8'h00
`define MSC_RST_FANCODE  8'hff
`define MSC_RST_PINS     4'h6
`define MSC_SLAVE_ADDR   8'h2e
`define MSC_FAN_FULL     8'hff
`define MSC_FAN_STOP     8'h00
`define MSC_IST_USED     8'h13

// ====================================================================
// timing
`define MSC_CLK_NS       4
`define MSC_RRST_NS      2000
`define MSC_RRST_CYC     (((`MSC_RRST_NS) + (`MSC_CLK_NS) - 1) / (`MSC_CLK_NS))

`endif

// [test/msc_ctrl_sva.sv]
// Purpose : port-level assertions for msc_ctrl
// Assumes : one clock domain, nrst_i asynchronous and active low
// Notes   : bound into msc_ctrl at the foot of this file
`timescale 1ns/10ps
`include "msc_consts.vh"
module msc_ctrl_sva
(
  input wire logic       sys_clk_i,                       // clock
  input wire logic       nrst_i,                          // reset, low active
  input wire logic       avs_waitrequest_o,               // bus stall
  input wire logic       temp_setpoint_violated_i,        // set point cause
  input wire logic       main_power_loss_n_i,             // power loss pin
  input wire logic [7:0] fan_speed_code_o,                // fan level
  input wire logic       fan_speed_oe_n_o,                // fan drive enable
  input wire logic       remote_reset_oe_n_o,             // remote reset pin
  input wire logic       overtemp_out_secondary_n_oe_n_o, // second alert pin
  input wire logic       int_pin_oe_n_o,                  // interrupt pin
  input wire logic       remote_power_off_o,              // power-off level
  input wire logic       irq_o                            // level interrupt
);
  localparam int RR_CYC = `MSC_RRST_CYC;
  logic [9:0] rr_cnt;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================
  // length of the remote reset pulse, too long for a repetition
  always @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
      rr_cnt <= 10'h000;
    else if (!remote_reset_oe_n_o)
      rr_cnt <= rr_cnt + 10'h001;
    else
      rr_cnt <= 10'h000;
  // ==========================
  // assertions
  a_wait_one:
    assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low twice");
  a_therm_pin:
    assert property (1'b1 |=> overtemp_out_secondary_n_oe_n_o == !$past(temp_setpoint_violated_i))
    else $error("alert pin off its cause");
  a_therm_fan:
    assert property (!overtemp_out_secondary_n_oe_n_o && !fan_speed_oe_n_o
                     |-> fan_speed_code_o == 8'hff) else $error("fan not full on alert");
  a_rrst_width:
    assert property ($rose(remote_reset_oe_n_o) |-> rr_cnt == RR_CYC) else $error("pulse width");
  a_rrst_bound:
    assert property (rr_cnt <= RR_CYC) else $error("pulse too long");
  a_pwr_loss:
    assert property ($fell(main_power_loss_n_i) |-> ##[1:8] (!remote_power_off_o && fan_speed_oe_n_o))
    else $error("power loss not obeyed");
  a_pwr_hold:
    assert property ((main_power_loss_n_i [*6] ##0 remote_power_off_o) |=> remote_power_off_o)
    else $error("power-off dropped");
  a_int_gate:
    assert property (!int_pin_oe_n_o |-> irq_o) else $error("int pin without pending");
endmodule // msc_ctrl_sva
bind msc_ctrl msc_ctrl_sva i_msc_ctrl_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .avs_waitrequest_o(avs_waitrequest_o), .temp_setpoint_violated_i(temp_setpoint_violated_i),
  .main_power_loss_n_i(main_power_loss_n_i), .fan_speed_code_o(fan_speed_code_o),
  .fan_speed_oe_n_o(fan_speed_oe_n_o), .remote_reset_oe_n_o(remote_reset_oe_n_o),
  .overtemp_out_secondary_n_oe_n_o(overtemp_out_secondary_n_oe_n_o),
  .int_pin_oe_n_o(int_pin_oe_n_o), .remote_power_off_o(remote_power_off_o), .irq_o(irq_o));

// [test/msc_board.sv]
// Purpose : board side of the open-drain pins of msc_ctrl
// Assumes : every open-drain pin has a pull-up on the board
// Notes   : index 0 fan off, 1 remote reset, 2 and 3 overtemp, 4 interrupt
`timescale 1ns/10ps
module msc_board
(
  input  wire logic [4:0] oe_n_i,  // pin pulled when 0
  input  wire logic [4:0] lvl_i,   // level while pulled
  output wire logic [4:0] pin_n_o  // resolved pin levels
);
  // ==========================
  // pull-up wins when released, so a stale driven level never shows
  assign pin_n_o = oe_n_i | lvl_i;
endmodule // msc_board

// [test/test_msc_ctrl.sv]
// Purpose : self-checking bench for msc_ctrl
// Assumes : register bus master per the hand-over timing
// Notes   : pins of the board seen through msc_board pull-ups
`timescale 1ns/10ps
`include "msc_consts.vh"
module test_msc_ctrl;
  logic        clk, rst_n, rd, wr, temp, trip, general_purpose_input, aux, pwr, tsel, wt, rpo, irq, fan_oe_n;
  logic [4:0]  addr, od_oe_n, od_lvl, pin_n;
  logic [31:0] wdata, rdata, d;
  logic [7:0]  fan;
  int          bad_count = 0;
  int          n_tests = 0;
  msc_ctrl i_msc_ctrl (.sys_clk_i(clk), .nrst_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'h1), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .temp_setpoint_violated_i(temp),
    .trip_point_violated_i(trip), .general_purpose_input_i(general_purpose_input), .standby_reset_in_n_i(aux),
    .main_power_loss_n_i(pwr), .fan_speed_analog_or_test_select_i(tsel),
    .fan_speed_code_o(fan), .fan_speed_oe_n_o(fan_oe_n), .fan_off_req_out_o(od_lvl[0]),
    .fan_off_req_oe_n_o(od_oe_n[0]), .remote_reset_out_o(od_lvl[1]),
    .remote_reset_oe_n_o(od_oe_n[1]), .overtemp_out_primary_n_out_o(od_lvl[2]),
    .overtemp_out_primary_n_oe_n_o(od_oe_n[2]), .overtemp_out_secondary_n_out_o(od_lvl[3]),
    .overtemp_out_secondary_n_oe_n_o(od_oe_n[3]), .int_pin_out_o(od_lvl[4]),
    .int_pin_oe_n_o(od_oe_n[4]), .remote_power_off_o(rpo), .irq_o(irq));
  msc_board i_msc_board (.oe_n_i(od_oe_n), .lvl_i(od_lvl), .pin_n_o(pin_n));
  // ==========================
  // clock and shared tasks
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bus cycle; request held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    int k;
    k = 0;
    addr <= a;
    wdata <= {24'h000000, v};
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wt !== 1'b0 && k < 40)
    begin
      k++;
      @(posedge clk);
    end
    d = rdata;
    if (k == 40)
      bad_count++;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task rchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(d, e);
  endtask
  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================
  // scenarios
  task t_defaults();
    rchk(`MSC_OFF_CFG, 8'h01);
    rchk(`MSC_OFF_ISTAT, 8'h00);
    bus(1'b1, `MSC_OFF_SLVADDR, 8'h11);
    rchk(`MSC_OFF_SLVADDR, 8'h2e);
    rchk(5'h1c, 8'h00);
    chk({irq, pin_n[4]}, 2'b01);
  endtask
  task t_gpi();
    general_purpose_input <= 1'b1;
    cyc(10);
    rchk(`MSC_OFF_ISTAT, 8'h10);
    chk({irq, pin_n[4]}, 2'b11);
    bus(1'b1, `MSC_OFF_CFG, 8'h03);
    cyc(2);
    chk(pin_n[4], 1'b0);
    bus(1'b1, `MSC_OFF_IMASK, 8'h10);
    cyc(2);
    chk({irq, pin_n[4]}, 2'b01);
    bus(1'b1, `MSC_OFF_CFG, 8'h02);
    bus(1'b1, `MSC_OFF_ISTAT, 8'h10);
    rchk(`MSC_OFF_ISTAT, 8'h00);
    general_purpose_input <= 1'b0;
    cyc(10);
    rchk(`MSC_OFF_ISTAT, 8'h10);
    bus(1'b1, `MSC_OFF_CFG, 8'h03);
    bus(1'b1, `MSC_OFF_ISTAT, 8'h10);
    bus(1'b1, `MSC_OFF_IMASK, 8'h00);
    cyc(2);
    chk(irq, 1'b0);
  endtask
  task t_trip_therm();
    trip <= 1'b1;
    @(posedge clk);
    trip <= 1'b0;
    cyc(3);
    chk({irq, pin_n[4]}, 2'b10);
    rchk(`MSC_OFF_ISTAT, 8'h01);
    bus(1'b1, `MSC_OFF_ISTAT, 8'h01);
    bus(1'b1, `MSC_OFF_FANCODE, 8'h40);
    temp <= 1'b1;
    cyc(3);
    chk({pin_n[3:2], fan_oe_n, fan}, {3'b000, 8'hff});
    temp <= 1'b0;
    cyc(3);
    chk({pin_n[3:2], fan}, {2'b11, 8'h40});
    bus(1'b1, `MSC_OFF_ISTAT, 8'h02);
  endtask
  task t_remote();
    bus(1'b1, `MSC_OFF_REMOTE, 8'h05);
    cyc(2);
    chk({rpo, pin_n[0]}, 2'b10);
    bus(1'b1, `MSC_OFF_REMOTE, 8'h03);
    cyc(2);
    chk({rpo, pin_n[1:0]}, 3'b101);
    rchk(`MSC_OFF_REMOTE, 8'h03);
    cyc(`MSC_RRST_CYC - 5);
    chk(pin_n[1], 1'b0);
    cyc(1);
    chk(pin_n[1], 1'b1);
    pwr <= 1'b0;
    cyc(10);
    chk({rpo, fan_oe_n, fan}, {2'b01, 8'h00});
    rchk(`MSC_OFF_REMOTE, 8'h00);
    pwr <= 1'b1;
    cyc(10);
    chk(rpo, 1'b0);
  endtask
  task t_test_aux();
    tsel <= 1'b1;
    cyc(10);
    chk({fan_oe_n, pin_n[2]}, 2'b10);
    rchk(`MSC_OFF_ALERT, 8'h0c);
    general_purpose_input <= 1'b1;
    cyc(10);
    chk(pin_n[2], 1'b1);
    general_purpose_input <= 1'b0;
    tsel <= 1'b0;
    cyc(10);
    chk(fan_oe_n, 1'b0);
    aux <= 1'b0;
    cyc(10);
    aux <= 1'b1;
    cyc(10);
    rchk(`MSC_OFF_FANCODE, 8'hff);
    rchk(`MSC_OFF_CFG, 8'h01);
  endtask
  // ==========================
  // main sequence and watchdog; the run is about 700 cycles
  initial
  begin
    {rst_n, rd, wr, temp, trip, general_purpose_input, tsel} = 7'h00;
    {aux, pwr} = 2'b11;
    addr = 5'h00;
    wdata = 32'h00000000;
    cyc(4);
    rst_n <= 1'b1;
    cyc(8);
    t_defaults();
    t_gpi();
    t_trip_therm();
    t_remote();
    t_test_aux();
    give_verdict();
  end
  initial
  begin
    #40000;
    bad_count++;
    give_verdict();
  end
endmodule // test_msc_ctrl
